// >>> rtl/rmd_params.svh
// Constants for the RS-485 turn-around and multi-drop address block.
// Assumes inclusion by rtl and bench files; definitions only.
`ifndef RMD_PARAMS_SVH
`define RMD_PARAMS_SVH
// Register indices on the 3-bit host address
`define RMD_ADDR_IER      3'h1
`define RMD_ADDR_LCR      3'h3
`define RMD_ADDR_MCR      3'h4
`define RMD_ADDR_LSR      3'h5
`define RMD_ADDR_RXD      3'h0
// Bit positions
`define RMD_AF2_NINE      0
`define RMD_AF2_RXEN      1
`define RMD_AF2_AUTORTS   4
`define RMD_AF2_RTSINV    5
`define RMD_EFR_SPECIAL   5
`define RMD_MCR_RTS       1
`define RMD_IER_RLS       2
`define RMD_LSR_DR        0
`define RMD_LSR_PE        2
`define RMD_LSR_THRE      5
`define RMD_LSR_TEMT      6
// Reset values
`define RMD_RST_REG       8'h00
`define RMD_RST_LSR       8'h09
// Buffer depth
`define RMD_FIFO_DEPTH    4
`endif

// >>> rtl/rmd_pkg.sv
// Types for the RS-485 turn-around and multi-drop address block.
// Assumes nothing of its surroundings.
package rmd_pkg;
  typedef enum logic [2:0] {
    RMD_RX_OFF  = 3'b001,
    RMD_RX_ON   = 3'b010,
    RMD_RX_HOLD = 3'b100
  } rmd_rx_state_t;
endpackage

// >>> rtl/rmd_fifo.sv
// Small valid/ready FIFO for received characters.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module rmd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = i_in_valid && o_in_ready;
  wire              pop  = o_out_valid && i_out_ready;

  // Honest full and empty from the occupancy count
  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];

  // Storage
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  // Pointers wrap at the depth
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// >>> rtl/rmd_rs485.sv
// RS-485 driver turn-around and 9-bit multi-drop receive filter.
// Assumes an external UART core: it reports transmit activity and hands
// in each received 8-bit character with its ninth (parity) bit.
// Behaviour
// - RTS follows modem control or flow logic; auto RS-485 bit overrides both.
// - Auto mode: RTS low on transmit write, high after last bit leaves.
// - Inversion bit: RTS high while sending, low after last bit.
// - Nine-bit mode: ninth bit 1 marks address, 0 marks data.
// - Normal mode, receiver off: data characters dropped until the host enables the receiver.
// - Normal mode address: parity error, stored, line status interrupt if enabled.
// - Normal mode, enabled receiver takes all; new address flagged with parity error.
// - Special detect: compare addresses with match register, drop others.
// - Matching address enables receiver, stored with ninth bit as error.
// - Enabled, non-match address disables receiver and is dropped.
`timescale 1ns/10ps
`include "rmd_params.svh"
module rmd_rs485 (
  input  wire logic       i_ref_clk,
  input  wire logic       i_nrst,
  // Host parallel bus
  input  wire logic [2:0] i_addr,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  // Enhanced and advanced feature settings, and match character
  input  wire logic [7:0] i_advanced_feature_control_two,
  input  wire logic [7:0] i_enhanced_feature_reg,
  input  wire logic [7:0] i_second_stop_char_reg,
  // Transmit status and flow control from the UART core
  input  wire logic       i_tx_write,
  input  wire logic       i_tx_done,
  input  wire logic       i_thr_empty,
  input  wire logic       i_flow_rts_n,
  input  wire logic       i_flow_en,
  // Received characters from the UART core
  input  wire logic       i_rx_valid,
  input  wire logic [7:0] i_rx_data,
  input  wire logic       i_rx_ninth,
  input  wire logic       i_rx_frame_err,
  // Pins and status
  output logic            o_rts_n,
  output logic            o_rx_enabled,
  output logic            o_line_irq,
  output logic            o_rx_overrun
);
  // Register state
  logic [7:0]              ier_q;
  logic [7:0]              lcr_q;
  logic [7:0]              mcr_q;
  logic                    pe_q;
  logic                    fe_q;
  logic                    oe_q;
  logic                    tx_busy_q;
  logic                    rts_q;
  logic [7:0]              rdata_q;
  logic                    irq_q;
  rmd_pkg::rmd_rx_state_t  rx_q;
  rmd_pkg::rmd_rx_state_t  rx_d;
  logic                    host_en_q;
  logic                    lsr_rst_q;

  // FIFO of received characters, ninth bit beside the data
  logic       f_in_ready;
  logic       f_out_valid;
  logic [8:0] f_out_data;
  logic       f_push;
  logic       f_pop;

  // Decoding
  wire wr_ier  = i_wr && (i_addr == `RMD_ADDR_IER);
  wire wr_lcr  = i_wr && (i_addr == `RMD_ADDR_LCR);
  wire wr_mcr  = i_wr && (i_addr == `RMD_ADDR_MCR);
  wire rd_lsr  = i_rd && (i_addr == `RMD_ADDR_LSR);
  wire rd_rxd  = i_rd && (i_addr == `RMD_ADDR_RXD) && !lcr_q[7];
  wire nine    = i_advanced_feature_control_two[`RMD_AF2_NINE];
  wire sw_rxen = i_advanced_feature_control_two[`RMD_AF2_RXEN];
  wire autorts = i_advanced_feature_control_two[`RMD_AF2_AUTORTS];
  wire rtsinv  = i_advanced_feature_control_two[`RMD_AF2_RTSINV];
  wire special = i_enhanced_feature_reg[`RMD_EFR_SPECIAL];

  // Character class and address match
  function automatic logic is_match(input logic [7:0] a,
                                    input logic [7:0] b);
    is_match = (a == b);
  endfunction

  wire is_addr = nine && i_rx_ninth;
  wire is_data = nine && !i_rx_ninth;
  wire matched = is_match(i_rx_data, i_second_stop_char_reg);
  wire rx_on   = (rx_q == rmd_pkg::RMD_RX_ON) || sw_rxen;

  // Receive acceptance decision
  logic keep;
  always_comb begin
    keep = 1'b0;
    rx_d = rx_q;
    if (i_rx_valid) begin
      if (!nine) begin
        keep = 1'b1;
      end else if (!special) begin
        keep = is_addr || rx_on;
      end else if (is_addr && matched) begin
        keep = 1'b1;
        rx_d = rmd_pkg::RMD_RX_ON;
      end else if (is_addr) begin
        keep = 1'b0;
        rx_d = rmd_pkg::RMD_RX_OFF;
      end else begin
        keep = rx_on;
      end
    end
    if (host_en_q != sw_rxen) begin
      rx_d = sw_rxen ? rmd_pkg::RMD_RX_ON : rmd_pkg::RMD_RX_OFF;
    end
  end

  assign f_push = i_rx_valid && keep;
  assign f_pop  = rd_rxd && f_out_valid;

  rmd_fifo #(
    .WIDTH (9),
    .DEPTH (`RMD_FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_nrst      (i_nrst),
    .i_in_valid  (f_push),
    .o_in_ready  (f_in_ready),
    .i_in_data   ({i_rx_ninth, i_rx_data}),
    .o_out_valid (f_out_valid),
    .i_out_ready (rd_rxd),
    .o_out_data  (f_out_data)
  );

  // Line status from FIFO head and sticky errors; reset image until traffic
  wire [7:0] lsr_live = {1'b0, !tx_busy_q && i_thr_empty, i_thr_empty, 1'b0,
                         fe_q, pe_q, oe_q, f_out_valid};
  wire [7:0] line_status      = lsr_rst_q ? `RMD_RST_LSR : lsr_live;
  // Next transmit activity drives the pin, so RTS moves one cycle after cause
  wire       tx_busy_d = i_tx_write ? 1'b1 :
                         (i_tx_done && i_thr_empty) ? 1'b0 : tx_busy_q;
  wire       rts_auto = rtsinv ? tx_busy_d : !tx_busy_d;
  wire       rts_norm = i_flow_en ? i_flow_rts_n : !mcr_q[`RMD_MCR_RTS];
  wire       rts_d    = autorts ? rts_auto : rts_norm;
  wire       irq_d    = ier_q[`RMD_IER_RLS] && (pe_q || fe_q || oe_q);
  logic [7:0] rdata_d;
  always_comb begin
    unique case (i_addr)
      `RMD_ADDR_RXD: rdata_d = lcr_q[7] ? 8'h00 : f_out_data[7:0];
      `RMD_ADDR_IER: rdata_d = ier_q;
      `RMD_ADDR_LCR: rdata_d = lcr_q;
      `RMD_ADDR_MCR: rdata_d = mcr_q;
      `RMD_ADDR_LSR: rdata_d = line_status;
      default:       rdata_d = 8'h00;
    endcase
  end

  // Host registers
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ier_q <= `RMD_RST_REG;
      lcr_q <= `RMD_RST_REG;
      mcr_q <= `RMD_RST_REG;
    end else begin
      if (wr_ier) ier_q <= i_wdata;
      if (wr_lcr) lcr_q <= i_wdata;
      if (wr_mcr) mcr_q <= i_wdata;
    end
  end

  // Sticky line errors; a new event wins over the clearing read
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      if (f_pop && f_out_data[8] && nine) begin
        pe_q <= 1'b1;
      end else if (rd_lsr) begin
        pe_q <= 1'b0;
      end
      if (f_push && i_rx_frame_err) begin
        fe_q <= 1'b1;
      end else if (rd_lsr) begin
        fe_q <= 1'b0;
      end
      if (f_push && !f_in_ready) begin
        oe_q <= 1'b1;
      end else if (rd_lsr) begin
        oe_q <= 1'b0;
      end
    end
  end

  // Transmit activity: set on a write, cleared when the last bit is out
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_busy_q <= 1'b0;
    end else begin
      tx_busy_q <= tx_busy_d;
    end
  end

  // Receiver enable state and registered outputs
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_q      <= rmd_pkg::RMD_RX_OFF;
      host_en_q <= 1'b0;
      rts_q     <= 1'b1;
      irq_q     <= 1'b0;
      rdata_q   <= 8'h00;
      lsr_rst_q <= 1'b1;
    end else begin
      lsr_rst_q <= lsr_rst_q && !f_push && !i_tx_write;
      rx_q      <= rx_d;
      host_en_q <= sw_rxen;
      rts_q     <= rts_d;
      irq_q     <= irq_d;
      rdata_q   <= rdata_d;
    end
  end

  assign o_rts_n      = rts_q;
  assign o_rdata      = rdata_q;
  assign o_line_irq   = irq_q;
  assign o_rx_enabled = rx_q[1]; // Flop bit of the one-hot enabled state
  assign o_rx_overrun = oe_q;
endmodule

// >>> bench/rmd_rs485_assertions.sv
// Checker for RTS turn-around and the address filter of the RS-485 block.
// Assumes binding to rmd_rs485; it sees only that module's ports.
`timescale 1ns/10ps
module rmd_rs485_chk (
  input wire logic       i_ref_clk,
  input wire logic       i_nrst,
  input wire logic [7:0] i_advanced_feature_control_two,
  input wire logic [7:0] i_enhanced_feature_reg,
  input wire logic [7:0] i_second_stop_char_reg,
  input wire logic       i_tx_write,
  input wire logic       i_tx_done,
  input wire logic       i_thr_empty,
  input wire logic       i_flow_rts_n,
  input wire logic       i_flow_en,
  input wire logic       i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic       i_rx_ninth,
  input wire logic       o_rts_n,
  input wire logic       o_rx_enabled
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // Short views of the settings
  wire [7:0] af   = i_advanced_feature_control_two;
  wire       au   = af[4];
  wire       spec = af[0] & i_enhanced_feature_reg[5] & ~af[1];
  wire       hit  = i_rx_data == i_second_stop_char_reg;
  // An address character arriving under automatic detection
  sequence s_addr_in;
    i_rx_valid && i_rx_ninth && spec;
  endsequence
  a_auto_rts_low: assert property (
    au && !af[5] && i_tx_write |=> !o_rts_n)
    else $error("rts not low after transmit write");
  a_auto_rts_high: assert property (
    au && !af[5] && i_tx_done && i_thr_empty && !i_tx_write |=> o_rts_n)
    else $error("rts not high after last bit");
  a_inv_rts_high: assert property (
    au && af[5] && i_tx_write |=> o_rts_n)
    else $error("inverted rts not high after write");
  a_inv_rts_low: assert property (
    au && af[5] && i_tx_done && i_thr_empty && !i_tx_write |=> !o_rts_n)
    else $error("inverted rts not low after last bit");
  a_flow_rts_follow: assert property (
    !au && i_flow_en |=> o_rts_n == $past(i_flow_rts_n))
    else $error("rts does not follow flow logic");
  a_data_no_wake: assert property (
    !o_rx_enabled && i_rx_valid && !i_rx_ninth && spec |=> !o_rx_enabled)
    else $error("data character woke the receiver");
  a_match_wakes: assert property (
    s_addr_in ##0 hit |=> o_rx_enabled)
    else $error("matching address did not enable receiver");
  a_miss_sleeps: assert property (
    s_addr_in ##0 !hit |=> !o_rx_enabled)
    else $error("other address left receiver enabled");
endmodule
bind rmd_rs485 rmd_rs485_chk chk (.i_ref_clk, .i_nrst,
  .i_advanced_feature_control_two, .i_enhanced_feature_reg,
  .i_second_stop_char_reg, .i_tx_write, .i_tx_done, .i_thr_empty,
  .i_flow_rts_n,
  .i_flow_en, .i_rx_valid, .i_rx_data, .i_rx_ninth, .o_rts_n,
  .o_rx_enabled);

// >>> bench/rmd_station.sv
// Model of the line side: remote stations and the transmit shifter.
// Assumes the bench calls send; reports the last bit a delay after writes.
`timescale 1ns/10ps
module rmd_station #(
  parameter int TX_CYC = 12
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_tx_write,
  output logic            o_tx_done,
  output logic            o_thr_empty,
  output logic            o_rx_valid,
  output logic      [7:0] o_rx_data,
  output logic            o_rx_ninth,
  output logic            o_rx_frame_err
);
  int cnt;
  // Shifter empties a fixed time after the newest write
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt         <= 0;
      o_tx_done   <= 1'b0;
      o_thr_empty <= 1'b1;
    end else begin
      cnt         <= i_tx_write ? TX_CYC : (cnt > 0 ? cnt - 1 : 0);
      o_tx_done   <= cnt == 1 && !i_tx_write;
      o_thr_empty <= !i_tx_write && cnt < TX_CYC - 2; // Holding stage drains
    end
  end
  initial begin
    {o_rx_valid, o_rx_ninth, o_rx_frame_err} = 3'h0;
    o_rx_data = 8'h00;
  end
  // One character with its ninth bit; lines change once released
  task automatic send(input logic [7:0] d, input logic n);
    @(posedge i_ref_clk);
    o_rx_valid <= 1'b1;
    o_rx_data  <= d;
    o_rx_ninth <= n;
    @(posedge i_ref_clk);
    o_rx_valid <= 1'b0;
    o_rx_data  <= ~d;
    o_rx_ninth <= ~n;
    @(posedge i_ref_clk);
  endtask
endmodule

// >>> bench/tb_rmd_rs485.sv
// Self-checking bench for the RS-485 turn-around and multi-drop block.
// Assumes the station model and the bound checker are compiled with it.
`timescale 1ns/10ps
`include "rmd_params.svh"
module tb_rmd_rs485;
  logic       clk, nrst, wr, rd, tw, td, rv, rn, fe, ov, rts, ren, irq;
  logic       fen, frts, te;
  logic [2:0] addr;
  logic [7:0] wd, q, rdat, rxd, af, enhanced_feature_reg, mch;
  logic [2:0] regs [4] = '{`RMD_ADDR_IER, `RMD_ADDR_LCR, `RMD_ADDR_MCR,
                           `RMD_ADDR_LSR};
  int         error_cnt, n_checks;
  rmd_rs485 uut (.i_ref_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wr(wr),
    .i_rd(rd), .i_wdata(wd), .o_rdata(rdat),
    .i_advanced_feature_control_two(af), .i_enhanced_feature_reg(enhanced_feature_reg),
    .i_second_stop_char_reg(mch), .i_tx_write(tw), .i_tx_done(td),
    .i_thr_empty(te), .i_flow_rts_n(frts), .i_flow_en(fen),
    .i_rx_valid(rv), .i_rx_data(rxd), .i_rx_ninth(rn),
    .i_rx_frame_err(fe), .o_rts_n(rts), .o_rx_enabled(ren),
    .o_line_irq(irq), .o_rx_overrun(ov));
  rmd_station m (.i_ref_clk(clk), .i_nrst(nrst), .i_tx_write(tw),
    .o_tx_done(td), .o_thr_empty(te), .o_rx_valid(rv), .o_rx_data(rxd),
    .o_rx_ninth(rn),
    .o_rx_frame_err(fe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Host bus cycles: one-cycle strobes, read data a cycle later
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    {addr, wd, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    q = rdat;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  // Bounded wait for the pin level, then compare
  task automatic wait_rts(input logic v);
    int k;
    k = 0;
    while (rts !== v && k < 100) begin
      @(posedge clk);
      k++;
    end
    chkb(rts, v);
    if (rts !== v) summarize();
  endtask
  task automatic txw;
    @(posedge clk) tw <= 1'b1;
    @(posedge clk) tw <= 1'b0;
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    {nrst, wr, rd, tw, fen, addr, wd, af, enhanced_feature_reg} = 32'h0;
    {frts, mch, error_cnt, n_checks} = {1'b1, 8'hA5, 64'h0};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    // Reset values, read-only status, unmapped write
    foreach (regs[i]) begin
      rd_reg(regs[i]);
      chk(q, (regs[i] == `RMD_ADDR_LSR) ? `RMD_RST_LSR : 8'h00);
    end
    chkb(rts, 1'b1);
    wr_reg(`RMD_ADDR_LSR, 8'hFF);
    rd_reg(`RMD_ADDR_LSR);
    chk(q, `RMD_RST_LSR);
    wr_reg(3'h7, 8'hFF);
    wr_reg(`RMD_ADDR_IER, 8'h04);
    rd_reg(`RMD_ADDR_IER);
    chk(q, 8'h04);
    // Pin source: modem control, flow logic, then transmitter
    wr_reg(`RMD_ADDR_MCR, 8'h02);
    wait_rts(1'b0);
    {fen, frts} <= 2'b11;
    wait_rts(1'b1);
    frts <= 1'b0;
    wait_rts(1'b0);
    frts <= 1'b1;
    wait_rts(1'b1);
    fen <= 1'b0;
    wait_rts(1'b0);
    af <= 8'h10;
    wait_rts(1'b1);
    txw();
    wait_rts(1'b0);
    wait_rts(1'b1);
    af <= 8'h30;
    txw();
    wait_rts(1'b1);
    wait_rts(1'b0);
    // Normal multi-drop with forced parity 0
    af <= 8'h01;
    wr_reg(`RMD_ADDR_LCR, 8'h38);
    m.send(8'h11, 1'b0);
    m.send(8'h42, 1'b1);
    rd_reg(`RMD_ADDR_RXD);
    chk(q, 8'h42);
    repeat (2) @(posedge clk);
    chkb(irq, 1'b1);
    rd_reg(`RMD_ADDR_LSR);
    chkb(q[2], 1'b1);
    repeat (2) @(posedge clk);
    chkb(irq, 1'b0);
    af <= 8'h03;
    m.send(8'h55, 1'b0);
    m.send(8'h77, 1'b1);
    rd_reg(`RMD_ADDR_RXD);
    chk(q, 8'h55);
    rd_reg(`RMD_ADDR_RXD);
    chk(q, 8'h77);
    rd_reg(`RMD_ADDR_LSR);
    chkb(q[2], 1'b1);
    // Masked interrupt, then overrun on the fifth character
    wr_reg(`RMD_ADDR_IER, 8'h00);
    for (int i = 0; i < 5; i++) m.send({5'h10, 3'(i)}, 1'b0);
    chkb(ov, 1'b1);
    chkb(irq, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rd_reg(`RMD_ADDR_RXD);
      chk(q, {5'h10, 3'(i)});
    end
    // Automatic address detection against the match character
    {af, enhanced_feature_reg} <= {8'h01, 8'h20};
    m.send(8'h10, 1'b0);
    m.send(8'hA4, 1'b1);
    chkb(ren, 1'b0);
    m.send(8'hA5, 1'b1);
    chkb(ren, 1'b1);
    m.send(8'h33, 1'b0);
    rd_reg(`RMD_ADDR_RXD);
    chk(q, 8'hA5);
    rd_reg(`RMD_ADDR_LSR);
    chkb(q[2], 1'b1);
    rd_reg(`RMD_ADDR_RXD);
    chk(q, 8'h33);
    m.send(8'h25, 1'b1);
    chkb(ren, 1'b0);
    m.send(8'h44, 1'b0);
    m.send(8'hA5, 1'b1);
    rd_reg(`RMD_ADDR_RXD);
    chk(q, 8'hA5);
    summarize();
  end
endmodule
